// ---- xpe_map.svh ----
// Byte patterns, lengths and code sets of the exception packet encoder.
`ifndef XPE_MAP_SVH
`define XPE_MAP_SVH

`define XPE_HDR_EXC        8'h06
`define XPE_HDR_EXACT      6'h24
`define XPE_HDR_SHORT_WIDE 8'h95
`define XPE_HDR_SHORT_NARR 8'h96
`define XPE_HDR_W32_WIDE   8'h9a
`define XPE_HDR_W32_NARR   8'h9b

`define XPE_SEL_HIST0      2'h0
`define XPE_SEL_HIST1      2'h1
`define XPE_SEL_HIST2      2'h2

`define XPE_ELEM_EXC       2'h1
`define XPE_ELEM_TGT_EXC   2'h2
`define XPE_KIND_FAIL      5'h18
`define XPE_KIND_OK_MASK   32'h00ffdcdf

`define XPE_LEN_EXACT      3'h3
`define XPE_LEN_SHORT1     3'h4
`define XPE_LEN_SHORT2     3'h5
`define XPE_LEN_W32        3'h7
`define XPE_BYTES          7

`endif

// ---- xpe_pkg.sv ----
// Types and code checks shared by the exception packet encoder.
`include "xpe_map.svh"
package xpe_pkg;

	typedef logic [1:0]  xpe_elem_t;
	typedef logic [4:0]  xpe_kind_t;
	typedef logic [31:0] xpe_addr_t;
	typedef logic [7:0]  xpe_byte_t;
	typedef logic [2:0]  xpe_len_t;

	typedef enum logic [1:0] {
		xpe_st_idle = 2'b01,
		xpe_st_send = 2'b10
	} xpe_state_t;

	function automatic logic xpe_kind_ok(input xpe_kind_t k);
		logic [31:0] m;
		m = `XPE_KIND_OK_MASK;
		return m[k];
	endfunction : xpe_kind_ok

	function automatic logic xpe_elem_ok(input xpe_elem_t e);
		return (e == `XPE_ELEM_EXC) || (e == `XPE_ELEM_TGT_EXC);
	endfunction : xpe_elem_ok

endpackage : xpe_pkg

// ---- xpe_pkt_if.sv ----
// Carrier between the encoder's request inputs and the variant picker.
`timescale 1ns/1ps
`include "xpe_map.svh"
interface xpe_pkt_if;
	import xpe_pkg::*;

	logic      narrow;
	xpe_elem_t elem;
	xpe_kind_t kind;
	xpe_addr_t addr;
	xpe_addr_t hist0;
	xpe_addr_t hist1;
	xpe_addr_t hist2;
	xpe_byte_t pkt [`XPE_BYTES];
	xpe_len_t  len;

	modport pick (
		input  narrow, elem, kind, addr, hist0, hist1, hist2,
		output pkt, len
	);
	modport use_side (
		output narrow, elem, kind, addr, hist0, hist1, hist2,
		input  pkt, len
	);
endinterface : xpe_pkt_if

// ---- xpe_pick.sv ----
// Chooses the shortest exception packet variant and lays out its bytes.
`timescale 1ns/1ps
`include "xpe_map.svh"
module xpe_pick (
	// Request in, packet bytes out.
	xpe_pkt_if.pick p
);
	import xpe_pkg::*;

	xpe_addr_t a;
	logic      more;

	always_comb begin
		// Dropped return address bits are forced to zero.
		if (p.narrow) begin
			a = {p.addr[31:1], 1'b0};
		end else begin
			a = {p.addr[31:2], 2'b00};
		end
		more = 1'b0;
		for (int i = 0; i < `XPE_BYTES; i++) begin
			p.pkt[i] = 8'h00;
		end
		p.pkt[0] = `XPE_HDR_EXC;
		p.pkt[1] = {1'b0, p.elem[1], p.kind, p.elem[0]};
		p.len    = `XPE_LEN_W32;
		if (a == p.hist0) begin
			p.pkt[2] = {`XPE_HDR_EXACT, `XPE_SEL_HIST0};
			p.len    = `XPE_LEN_EXACT;
		end else if (a == p.hist1) begin
			p.pkt[2] = {`XPE_HDR_EXACT, `XPE_SEL_HIST1};
			p.len    = `XPE_LEN_EXACT;
		end else if (a == p.hist2) begin
			p.pkt[2] = {`XPE_HDR_EXACT, `XPE_SEL_HIST2};
			p.len    = `XPE_LEN_EXACT;
		end else if (p.narrow) begin
			if (a[31:16] == p.hist0[31:16]) begin
				more     = (a[15:8] != p.hist0[15:8]);
				p.pkt[2] = `XPE_HDR_SHORT_NARR;
				p.pkt[3] = {more, a[7:1]};
				p.pkt[4] = a[15:8];
				p.len    = more ? `XPE_LEN_SHORT2 : `XPE_LEN_SHORT1;
			end else begin
				p.pkt[2] = `XPE_HDR_W32_NARR;
				p.pkt[3] = {1'b0, a[7:1]};
				p.pkt[4] = a[15:8];
				p.pkt[5] = a[23:16];
				p.pkt[6] = a[31:24];
			end
		end else begin
			if (a[31:17] == p.hist0[31:17]) begin
				more     = (a[16:9] != p.hist0[16:9]);
				p.pkt[2] = `XPE_HDR_SHORT_WIDE;
				p.pkt[3] = {more, a[8:2]};
				p.pkt[4] = a[16:9];
				p.len    = more ? `XPE_LEN_SHORT2 : `XPE_LEN_SHORT1;
			end else begin
				p.pkt[2] = `XPE_HDR_W32_WIDE;
				p.pkt[3] = {1'b0, a[8:2]};
				p.pkt[4] = {1'b0, a[15:9]};
				p.pkt[5] = a[23:16];
				p.pkt[6] = a[31:24];
			end
		end
	end

endmodule : xpe_pick

// ---- xpe_encoder.sv ----
// Exception trace packet encoder: takes requests, streams packet bytes.
`timescale 1ns/1ps
`include "xpe_map.svh"
// How it works
// - Exact-match third byte holds fixed header in bits 7:2, entry select below.
// - Select code 00, 01, 10 names history entry 0, 1, 2.
// - Second byte: bit7 zero, selector high bit, five-bit kind, selector low bit.
// - Selector 01 is a lone exception; 10 is target address then exception.
// - Reserved selector or kind values are never emitted; such requests are refused.
// - Only the listed exception kind codes are accepted.
// - Kind 11000 is refused here; failures use another packet.
// - Wide short form: header 95, continuation byte with bits 8:2, optional 16:9.
// - Narrow short form: header 96, continuation byte with bits 7:1, optional 15:8.
// - Continuation flag is one when another address byte follows, else zero.
// - Wide 32-bit form: header 9a, then 8:2, 15:9, 23:16, 31:24.
// - Narrow 32-bit form: header 9b, then 7:1, 15:8, 23:16, 31:24.
// - Wide return address bits 1:0 are zero and never sent.
// - Narrow return address bit 0 is zero and never sent.
// - Sent bits replace low bits of history entry 0; upper bits kept.
// - Every packet starts with header byte 06.
module xpe_encoder (
	// Clock and reset.
	input  wire logic           clk,
	input  wire logic           rst,
	// Exception request.
	input  wire logic           req_valid,
	output logic                req_ready,
	input  wire logic           req_narrow,
	input  wire xpe_pkg::xpe_elem_t req_elem,
	input  wire xpe_pkg::xpe_kind_t req_kind,
	input  wire xpe_pkg::xpe_addr_t req_addr,
	output logic                req_reject,
	// Address history entries.
	input  wire xpe_pkg::xpe_addr_t hist0,
	input  wire xpe_pkg::xpe_addr_t hist1,
	input  wire xpe_pkg::xpe_addr_t hist2,
	// Byte stream toward the trace analyzer.
	output logic                byte_valid,
	input  wire logic           byte_ready,
	output xpe_pkg::xpe_byte_t  byte_data,
	output logic                byte_last
);
	import xpe_pkg::*;

	xpe_pkt_if  pif ();
	xpe_state_t state_reg;
	xpe_byte_t  pkt_reg [`XPE_BYTES];
	xpe_len_t   len_reg;
	xpe_len_t   idx_reg;
	logic       req_ready_reg;
	logic       req_reject_reg;
	logic       byte_valid_reg;
	logic       byte_last_reg;
	xpe_byte_t  byte_data_reg;
	logic       take;
	logic       good;
	logic       step;
	logic       at_end;

	assign pif.narrow = req_narrow;
	assign pif.elem   = req_elem;
	assign pif.kind   = req_kind;
	assign pif.addr   = req_addr;
	assign pif.hist0  = hist0;
	assign pif.hist1  = hist1;
	assign pif.hist2  = hist2;

	xpe_pick u_pick (
		.p (pif.pick)
	);

	// A request is taken only while no packet is in flight.
	assign take   = req_valid && req_ready_reg;
	assign good   = xpe_kind_ok(req_kind) && xpe_elem_ok(req_elem);
	assign step   = byte_valid_reg && byte_ready;
	assign at_end = (idx_reg == len_reg - 3'h1);

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= xpe_st_idle;
		end else begin
			case (state_reg)
				xpe_st_idle: begin
					if (take && good) begin
						state_reg <= xpe_st_send;
					end
				end
				xpe_st_send: begin
					if (step && at_end) begin
						state_reg <= xpe_st_idle;
					end
				end
				default: begin
					state_reg <= xpe_st_idle;
				end
			endcase
		end
	end

	// The packet is frozen at acceptance so history changes cannot tear it.
	always_ff @(posedge clk) begin
		if (rst) begin
			len_reg <= `XPE_LEN_EXACT;
			for (int i = 0; i < `XPE_BYTES; i++) begin
				pkt_reg[i] <= 8'h00;
			end
		end else if (take && good) begin
			len_reg <= pif.len;
			for (int i = 0; i < `XPE_BYTES; i++) begin
				pkt_reg[i] <= pif.pkt[i];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			req_ready_reg  <= 1'b1;
			req_reject_reg <= 1'b0;
		end else begin
			req_reject_reg <= take && !good;
			if (take && good) begin
				req_ready_reg <= 1'b0;
			end else if (step && at_end) begin
				req_ready_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			idx_reg        <= 3'h0;
			byte_valid_reg <= 1'b0;
			byte_data_reg  <= 8'h00;
			byte_last_reg  <= 1'b0;
		end else if (take && good) begin
			idx_reg        <= 3'h0;
			byte_valid_reg <= 1'b1;
			byte_data_reg  <= pif.pkt[0];
			byte_last_reg  <= 1'b0;
		end else if (step) begin
			if (at_end) begin
				byte_valid_reg <= 1'b0;
				byte_last_reg  <= 1'b0;
			end else begin
				idx_reg       <= idx_reg + 3'h1;
				byte_data_reg <= pkt_reg[idx_reg + 3'h1];
				byte_last_reg <= (idx_reg + 3'h2 == len_reg);
			end
		end
	end

	assign req_ready  = req_ready_reg;
	assign req_reject = req_reject_reg;
	assign byte_valid = byte_valid_reg;
	assign byte_data  = byte_data_reg;
	assign byte_last  = byte_last_reg;

	hdr_first_a: assert property (@(posedge clk) disable iff (rst)
		take && good |=> byte_valid && byte_data == `XPE_HDR_EXC
			&& idx_reg == 3'h0)
		else $error("first byte is not the exception header");

	sel_byte_a: assert property (@(posedge clk) disable iff (rst)
		byte_valid && idx_reg == 3'h1 |-> !byte_data[7])
		else $error("selector byte has bit 7 set");

	legal_codes_a: assert property (@(posedge clk) disable iff (rst)
		byte_valid && idx_reg == 3'h1 |-> xpe_kind_ok(byte_data[5:1])
			&& byte_data[5:1] != `XPE_KIND_FAIL
			&& xpe_elem_ok({byte_data[6], byte_data[0]}))
		else $error("reserved selector or kind emitted");

	exact_end_a: assert property (@(posedge clk) disable iff (rst)
		byte_valid && idx_reg == 3'h2 && byte_data[7:2] == `XPE_HDR_EXACT
			|-> byte_last && byte_data[1:0] != 2'h3)
		else $error("exact match packet not closed at third byte");

	short_cont_a: assert property (@(posedge clk) disable iff (rst)
		byte_valid && idx_reg == 3'h3
			&& (pkt_reg[2] == `XPE_HDR_SHORT_WIDE
			|| pkt_reg[2] == `XPE_HDR_SHORT_NARR)
			|-> byte_data[7] == !byte_last)
		else $error("continuation flag disagrees with packet end");

	wide32_pad_a: assert property (@(posedge clk) disable iff (rst)
		byte_valid && pkt_reg[2] == `XPE_HDR_W32_WIDE
			&& (idx_reg == 3'h3 || idx_reg == 3'h4) |-> !byte_data[7])
		else $error("wide 32-bit address byte has bit 7 set");

	refuse_a: assert property (@(posedge clk) disable iff (rst)
		take && req_kind == `XPE_KIND_FAIL
			|=> req_reject && !byte_valid && req_ready)
		else $error("failure kind was not refused");

	// Checked on the frozen packet so a stalled analyzer cannot hide it.
	exact_hit_a: assert property (@(posedge clk) disable iff (rst)
		take && good && !req_narrow
			&& {req_addr[31:2], 2'b00} == hist0
			|=> pkt_reg[2] == {`XPE_HDR_EXACT, `XPE_SEL_HIST0}
			&& len_reg == `XPE_LEN_EXACT)
		else $error("entry 0 match not encoded by reference");

	hold_a: assert property (@(posedge clk) disable iff (rst)
		byte_valid && !byte_ready |=> byte_valid && $stable(byte_data))
		else $error("byte changed while stalled");

	// Refusals may follow each other every cycle, so only the cause is checked.
	reject_pulse_a: assert property (@(posedge clk) disable iff (rst)
		req_reject |-> $past(take && !good))
		else $error("refusal pulse without a refused request");

	busy_hold_a: assert property (@(posedge clk) disable iff (rst)
		byte_valid |-> !req_ready)
		else $error("request could be taken while a packet is in flight");

	last_pos_a: assert property (@(posedge clk) disable iff (rst)
		byte_valid && byte_last |-> idx_reg == len_reg - 3'h1)
		else $error("last flag not on the final byte");

	narrow32_pad_a: assert property (@(posedge clk) disable iff (rst)
		byte_valid && pkt_reg[2] == `XPE_HDR_W32_NARR
			&& idx_reg == 3'h3 |-> !byte_data[7])
		else $error("narrow 32-bit first address byte has bit 7 set");

	short_len_a: assert property (@(posedge clk) disable iff (rst)
		byte_valid && idx_reg == 3'h2
			&& (pkt_reg[2] == `XPE_HDR_SHORT_WIDE
			|| pkt_reg[2] == `XPE_HDR_SHORT_NARR)
			|-> len_reg == `XPE_LEN_SHORT1 || len_reg == `XPE_LEN_SHORT2)
		else $error("short packet has the wrong length");

endmodule : xpe_encoder

// ---- xpe_sink.sv ----
// Trace analyzer model that collects packet bytes, stalling on demand.
`timescale 1ns/1ps
module xpe_sink (
	// Clock, reset and stall control.
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               stall,
	// Byte stream from the encoder.
	input  wire logic               byte_valid,
	input  wire xpe_pkg::xpe_byte_t byte_data,
	input  wire logic               byte_last,
	output logic                    byte_ready,
	// Collected packet.
	output xpe_pkg::xpe_byte_t      got [8],
	output int                      got_n,
	output logic                    done
);
	import xpe_pkg::*;

	int n;

	initial byte_ready = 1'b0;

	always @(posedge clk) begin
		done <= 1'b0;
		if (rst) begin
			n <= 0;
		end else if (byte_valid && byte_ready) begin
			got[n] <= byte_data;
			n      <= byte_last ? 0 : n + 1;
			if (byte_last) begin
				got_n <= n + 1;
				done  <= 1'b1;
			end
		end
		// A slow analyzer takes a byte only every other cycle.
		byte_ready <= #1 !rst && (!stall || !byte_ready);
	end
endmodule : xpe_sink

// ---- tb.sv ----
// Self-checking bench for the exception packet encoder.
`timescale 1ns/1ps
module tb;
	import xpe_pkg::*;

	logic      clk, rst, stall, req_valid, req_ready, req_narrow;
	logic      req_reject, byte_valid, byte_ready, byte_last, done;
	xpe_elem_t req_elem;
	xpe_kind_t req_kind;
	xpe_addr_t req_addr, hist0, hist1, hist2;
	xpe_byte_t byte_data;
	xpe_byte_t got [8];
	xpe_byte_t ex [8];
	int        got_n, ex_n, n_mismatch, checks_done;

	xpe_encoder xpe_encoder_i (.clk, .rst, .req_valid, .req_ready,
		.req_narrow, .req_elem, .req_kind, .req_addr, .req_reject, .hist0,
		.hist1, .hist2, .byte_valid, .byte_ready, .byte_data, .byte_last);
	xpe_sink xpe_sink_i (.clk, .rst, .stall, .byte_valid, .byte_data,
		.byte_last, .byte_ready, .got, .got_n, .done);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim

	task automatic tick();
		@(posedge clk);
		#1;
	endtask : tick

	// Expected bytes for the request now on the inputs.
	task automatic model();
		xpe_addr_t m;
		logic      c, u, w;
		w = req_narrow;
		m = w ? {req_addr[31:1], 1'b0} : {req_addr[31:2], 2'h0};
		u = w ? m[31:16] === hist0[31:16] : m[31:17] === hist0[31:17];
		ex[0] = 8'h06;
		ex[1] = {1'b0, req_elem[1], req_kind, req_elem[0]};
		if (m === hist0 || m === hist1 || m === hist2) begin
			ex[2] = {6'h24, m === hist0 ? 2'h0 : m === hist1 ? 2'h1 : 2'h2};
			ex_n = 3;
		end else if (u) begin
			c = w ? m[15:8] !== hist0[15:8] : m[16:9] !== hist0[16:9];
			ex[2] = w ? 8'h96 : 8'h95;
			ex[3] = {c, w ? m[7:1] : m[8:2]};
			ex[4] = w ? m[15:8] : m[16:9];
			ex_n = c ? 5 : 4;
		end else begin
			ex[2] = w ? 8'h9b : 8'h9a;
			ex[3] = {1'b0, w ? m[7:1] : m[8:2]};
			ex[4] = w ? m[15:8] : {1'b0, m[15:9]};
			ex[5] = m[23:16];
			ex[6] = m[31:24];
			ex_n = 7;
		end
	endtask : model

	// Presents one request and judges the packet or the refusal.
	task automatic send(input logic nw, input xpe_elem_t e,
		input xpe_kind_t k, input xpe_addr_t a, input logic bad);
		int i;
		for (i = 0; i < 50 && req_ready !== 1'b1; i++) tick();
		if (i == 50) begin
			n_mismatch++;
			end_sim();
		end
		req_narrow = nw;
		req_elem = e;
		req_kind = k;
		req_addr = a;
		req_valid = 1'b1;
		model();
		tick();
		req_valid = 1'b0;
		chk(req_ready, bad);
		if (bad) begin
			chk(req_reject, 1'b1);
			chk(byte_valid, 1'b0);
			// Let an edge pass so the next request is a fresh one.
			tick();
			chk(req_reject, 1'b0);
			return;
		end
		chk(byte_valid, 1'b1);
		chk(byte_data, 8'h06);
		for (i = 0; i < 60 && done !== 1'b1; i++) tick();
		if (i == 60) begin
			n_mismatch++;
			end_sim();
		end
		chk(got_n, ex_n);
		for (i = 0; i < ex_n; i++) chk(got[i], ex[i]);
	endtask : send

	task automatic t_exact();
		hist0 = 32'h1000_0000;
		hist1 = 32'h2000_0004;
		hist2 = 32'h3000_0002;
		send(1'b0, 2'h1, 5'h0e, 32'h1000_0003, 1'b0);
		send(1'b1, 2'h2, 5'h0f, 32'h2000_0005, 1'b0);
		send(1'b1, 2'h1, 5'h00, 32'h3000_0002, 1'b0);
	endtask : t_exact

	task automatic t_short();
		stall = 1'b1;
		hist0 = 32'h1234_5678;
		send(1'b0, 2'h1, 5'h01, 32'h1234_56f0, 1'b0);
		send(1'b0, 2'h2, 5'h02, 32'h1235_0000, 1'b0);
		send(1'b1, 2'h1, 5'h03, 32'h1234_5601, 1'b0);
		send(1'b1, 2'h2, 5'h04, 32'h1234_0100, 1'b0);
		stall = 1'b0;
	endtask : t_short

	task automatic t_w32();
		send(1'b0, 2'h1, 5'h06, 32'hfedc_ba9b, 1'b0);
		send(1'b1, 2'h2, 5'h07, 32'h8765_4321, 1'b0);
	endtask : t_w32

	// Every kind code, then both reserved selectors.
	task automatic t_kinds();
		logic [31:0] ok;
		ok = 32'h00ff_dcdf;
		hist0 = 32'h0000_0040;
		for (int k = 0; k < 32; k++) begin
			send(1'b0, 2'h1, k[4:0], 32'h40, !ok[k]);
		end
		send(1'b0, 2'h0, 5'h01, 32'h40, 1'b1);
		send(1'b0, 2'h3, 5'h01, 32'h40, 1'b1);
	endtask : t_kinds

	// Reset in mid-packet, then a fresh packet must come out whole.
	task automatic t_reset();
		hist0 = 32'h0000_0040;
		req_narrow = 1'b0;
		req_elem = 2'h1;
		req_kind = 5'h01;
		req_addr = 32'h0000_0040;
		req_valid = 1'b1;
		tick();
		req_valid = 1'b0;
		tick();
		rst = 1'b1;
		tick();
		tick();
		chk(req_ready, 1'b1);
		chk(req_reject, 1'b0);
		chk(byte_valid, 1'b0);
		chk(byte_last, 1'b0);
		chk(byte_data, 8'h00);
		rst = 1'b0;
		send(1'b1, 2'h2, 5'h0e, 32'h0000_0040, 1'b0);
	endtask : t_reset

	initial begin
		rst = 1'b1;
		stall = 1'b0;
		req_valid = 1'b0;
		req_narrow = 1'b0;
		req_elem = 2'h1;
		req_kind = 5'h00;
		req_addr = 32'h0;
		hist0 = 32'h0;
		hist1 = 32'h0;
		hist2 = 32'h0;
		n_mismatch = 0;
		checks_done = 0;
		repeat (5) @(posedge clk);
		#1;
		rst = 1'b0;
		t_exact();
		t_short();
		t_w32();
		t_kinds();
		t_reset();
		end_sim();
	end
endmodule : tb
